/* File: rtl/scp_pkg.sv */
package scp_pkg;

    // serial command codes (three bits after the start bit)
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;

    // register indices in the 256-byte space
    localparam logic [7:0] IDX_PANEL_CONTROL = 8'h02;
    localparam logic [7:0] IDX_AUX_CONTROL = 8'h03;
    // pattern memories occupy this index and everything above it
    localparam logic [7:0] PATTERN_BASE = 8'h40;

    // field positions and reset values
    localparam int RUN_BIT = 6;
    localparam int SOFT_RST_BIT = 7;
    localparam logic [7:0] SOFT_RST_MASK = 8'h80;
    localparam logic [7:0] PANEL_CONTROL_RST = 8'h00;
    localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
    localparam logic [7:0] LOCKED_READ_VALUE = 8'h00;

    // internal reset release: serial clock pulses, then pixel clock pulses
    localparam logic [3:0] RST_SCLK_PULSES = 4'h4;
    localparam logic [3:0] RST_PIX_PULSES = 4'hA;

    // serial bit counts
    localparam logic [2:0] CMD_LAST = 3'h2;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    // transaction states, gray coded along the usual path
    typedef enum logic [2:0] {
        SCP_IDLE = 3'h0,
        SCP_CMD = 3'h1,
        SCP_ADDR = 3'h3,
        SCP_RIDLE = 3'h2,
        SCP_RDATA = 3'h6,
        SCP_WDATA = 3'h7,
        SCP_WIDLE = 3'h5,
        SCP_DONE = 3'h4
    } scp_state_t;

    // internal reset sequence states
    typedef enum logic [1:0] {
        SCP_RS_SCLK = 2'h0,
        SCP_RS_PIX = 2'h1,
        SCP_RS_RUN = 2'h3
    } scp_rst_t;

endpackage

/* File: rtl/scp_sync.sv */
`timescale 1ns/10ps

module scp_sync #(
    parameter int W = 5
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } scp_sync_t;

    scp_sync_t q;
    scp_sync_t n;

    // s1 feeds only s2; a bit counts once s2 and s3 agree, else it holds
    always_comb begin
        n = q;
        n.s1 = async_in;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level = q.lvl;

endmodule

/* File: rtl/scp_port.sv */
`timescale 1ns/10ps

// Notes on behaviour
// - one byte moves per transaction, eight-bit address over 256 locations
// - with run set, only indices 02h and 03h stay writable
// - with run set, writes to locked registers or patterns change nothing
// - with run set, pattern memory reads return 00h
// - with run clear, power request is ignored and all writes land, except that bit 7 of a write to 03h is not stored
// - with run set, panel powers only while power request is asserted
// - three-bit command follows: 000 read, 001 write; no others
// - read: one idle bit after address, then eight data bits out
// - select and serial input are sampled on serial clock rising edge
// - serial output changes on serial clock rising edge
// - after reset, wait four serial then ten pixel clock pulses
module scp_port (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic serial_clk,
    input wire logic serial_select,
    input wire logic serial_in,
    input wire logic pixel_clock,
    input wire logic panel_power_request_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic panel_power_on,
    output logic internal_reset,
    output logic [7:0] panel_control
);

    typedef struct packed {
        scp_pkg::scp_state_t st;
        scp_pkg::scp_rst_t rst_st;
        logic [2:0] cnt;
        logic [3:0] rst_cnt;
        logic [2:0] cmd;
        logic [7:0] addr;
        logic [7:0] sh;
        logic oe;
        logic sclk_prev;
        logic pix_prev;
        logic [255:0][7:0] mem;
    } scp_regs_t;

    scp_regs_t q;
    scp_regs_t n;
    logic [4:0] lvl;
    logic sclk, sel, din, pix, preq;
    logic sclk_rise, pix_rise, run, commit;
    logic [7:0] wbyte;

    // every check below runs on the core clock and sleeps through reset
    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (srst);

    function automatic logic is_pattern(input logic [7:0] a);
        is_pattern = (a >= scp_pkg::PATTERN_BASE);
    endfunction
    // only control indices stay open once the panel runs
    function automatic logic writable(input logic [7:0] a, input logic r);
        writable = !r || (a == scp_pkg::IDX_PANEL_CONTROL) ||
                   (a == scp_pkg::IDX_AUX_CONTROL);
    endfunction
    function automatic logic [7:0] read_byte(input logic [7:0] a,
                                             input logic r,
                                             input logic [255:0][7:0] m);
        if (r && is_pattern(a)) begin
            read_byte = scp_pkg::LOCKED_READ_VALUE;
        end else begin
            read_byte = m[a];
        end
    endfunction

    scp_sync #(
        .W(5)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in({panel_power_request_in, pixel_clock, serial_in,
                   serial_select, serial_clk}),
        .level(lvl)
    );

    assign {preq, pix, din, sel, sclk} = lvl;
    // all three serial inputs share one synchroniser depth, so din and sel
    // are seen with the same lag as the clock edge they belong to
    assign sclk_rise = sclk & ~q.sclk_prev;
    assign pix_rise = pix & ~q.pix_prev;
    assign run = q.mem[scp_pkg::IDX_PANEL_CONTROL][scp_pkg::RUN_BIT];
    assign wbyte = {q.sh[6:0], din};
    assign commit = sclk_rise && sel && (q.st == scp_pkg::SCP_WDATA) &&
                    (q.cnt == scp_pkg::BYTE_LAST);

    always_comb begin
        n = q;
        n.sclk_prev = sclk;
        n.pix_prev = pix;

        // internal reset release sequence
        case (q.rst_st)
            scp_pkg::SCP_RS_SCLK: begin
                if (sclk_rise) begin
                    if (q.rst_cnt == scp_pkg::RST_SCLK_PULSES - 4'h1) begin
                        n.rst_st = scp_pkg::SCP_RS_PIX;
                        n.rst_cnt = 4'h0;
                    end else begin
                        n.rst_cnt = q.rst_cnt + 4'h1;
                    end
                end
            end
            scp_pkg::SCP_RS_PIX: begin
                if (pix_rise) begin
                    if (q.rst_cnt == scp_pkg::RST_PIX_PULSES - 4'h1) begin
                        n.rst_st = scp_pkg::SCP_RS_RUN;
                        n.rst_cnt = 4'h0;
                    end else begin
                        n.rst_cnt = q.rst_cnt + 4'h1;
                    end
                end
            end
            scp_pkg::SCP_RS_RUN: begin
            end
            default: begin
                n.rst_st = scp_pkg::SCP_RS_SCLK;
                n.rst_cnt = 4'h0;
            end
        endcase

        if (sclk_rise) begin
            case (q.st)
                scp_pkg::SCP_IDLE: begin
                    if (sel && din) begin
                        n.st = scp_pkg::SCP_CMD;
                        n.cnt = 3'h0;
                    end
                end
                scp_pkg::SCP_CMD: begin
                    n.cmd = {q.cmd[1:0], din};
                    if (q.cnt == scp_pkg::CMD_LAST) begin
                        n.st = scp_pkg::SCP_ADDR;
                        n.cnt = 3'h0;
                    end else begin
                        n.cnt = q.cnt + 3'h1;
                    end
                end
                scp_pkg::SCP_ADDR: begin
                    n.addr = {q.addr[6:0], din};
                    if (q.cnt == scp_pkg::BYTE_LAST) begin
                        n.cnt = 3'h0;
                        // unknown codes wait out the frame silently
                        if (q.cmd == scp_pkg::CMD_READ) begin
                            n.st = scp_pkg::SCP_RIDLE;
                        end else if (q.cmd == scp_pkg::CMD_WRITE) begin
                            n.st = scp_pkg::SCP_WDATA;
                        end else begin
                            n.st = scp_pkg::SCP_DONE;
                        end
                    end else begin
                        n.cnt = q.cnt + 3'h1;
                    end
                end
                scp_pkg::SCP_RIDLE: begin
                    n.sh = read_byte(q.addr, run, q.mem);
                    n.oe = 1'b1;
                    n.st = scp_pkg::SCP_RDATA;
                    n.cnt = 3'h0;
                end
                scp_pkg::SCP_RDATA: begin
                    if (q.cnt == scp_pkg::BYTE_LAST) begin
                        n.oe = 1'b0;
                        n.st = scp_pkg::SCP_DONE;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.cnt = q.cnt + 3'h1;
                    end
                end
                scp_pkg::SCP_WDATA: begin
                    n.sh = wbyte;
                    if (q.cnt == scp_pkg::BYTE_LAST) begin
                        n.st = scp_pkg::SCP_WIDLE;
                    end else begin
                        n.cnt = q.cnt + 3'h1;
                    end
                end
                scp_pkg::SCP_WIDLE: begin
                    n.st = scp_pkg::SCP_DONE;
                end
                scp_pkg::SCP_DONE: begin
                end
                default: begin
                    n.st = scp_pkg::SCP_IDLE;
                end
            endcase
        end
        // locked writes fall through with no effect
        if (commit && writable(q.addr, run)) begin
            if ((q.addr == scp_pkg::IDX_AUX_CONTROL) &&
                wbyte[scp_pkg::SOFT_RST_BIT]) begin
                n.mem[scp_pkg::IDX_PANEL_CONTROL] =
                    scp_pkg::PANEL_CONTROL_RST;
                n.mem[scp_pkg::IDX_AUX_CONTROL] =
                    wbyte & ~scp_pkg::SOFT_RST_MASK;
                n.rst_st = scp_pkg::SCP_RS_SCLK;
                n.rst_cnt = 4'h0;
            end else begin
                n.mem[q.addr] = wbyte;
            end
        end
        // deselect aborts any frame and frees the output at once
        if (!sel) begin
            n.st = scp_pkg::SCP_IDLE;
            n.oe = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign serial_out = q.sh[7];
    assign serial_out_oe = q.oe;
    assign internal_reset = (q.rst_st != scp_pkg::SCP_RS_RUN);
    assign panel_power_on = run && preq && !internal_reset;
    assign panel_control = q.mem[scp_pkg::IDX_PANEL_CONTROL];

    property p_oe_window;
        q.oe |-> (q.st == scp_pkg::SCP_RDATA);
    endproperty
    a_oe_window: assert property (p_oe_window)
        else $error("serial output driven outside read data");
    property p_power_gate;
        panel_power_on |-> (run && preq);
    endproperty
    a_power_gate: assert property (p_power_gate)
        else $error("panel powered without run bit and request");
    property p_locked_write;
        (commit && !writable(q.addr, run)) |=>
            $stable(q.mem);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("locked location changed by a write");
    property p_write_lands;
        (commit && !run && (q.addr != scp_pkg::IDX_AUX_CONTROL)) |=>
            (q.mem[$past(q.addr)] == $past(wbyte));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("open write did not land");
    property p_read_load;
        (sclk_rise && sel && (q.st == scp_pkg::SCP_RIDLE) &&
         !(run && is_pattern(q.addr))) |=>
            (q.oe && (q.sh == $past(q.mem[q.addr])));
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("read byte not presented after idle bit");
    property p_read_end;
        (sclk_rise && (q.st == scp_pkg::SCP_RDATA) &&
         (q.cnt == scp_pkg::BYTE_LAST)) |=> !q.oe;
    endproperty
    a_read_end: assert property (p_read_end)
        else $error("serial output held past eighth bit");
    property p_bad_cmd;
        (sclk_rise && sel && (q.st == scp_pkg::SCP_ADDR) &&
         (q.cnt == scp_pkg::BYTE_LAST) && (q.cmd[2:1] != 2'h0)) |=>
            (q.st == scp_pkg::SCP_DONE) ##1 !q.oe;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd)
        else $error("undefined command started a transfer");
    property p_out_on_rise;
        $changed(serial_out) |-> $past(sclk_rise);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise)
        else $error("serial output moved without a serial clock rise");
    property p_addr_msb;
        (sclk_rise && sel && (q.st == scp_pkg::SCP_ADDR)) |=>
            (q.addr[0] == $past(din)) && (q.addr[7:1] == $past(q.addr[6:0]));
    endproperty
    a_addr_msb: assert property (p_addr_msb)
        else $error("address not shifted msb first");
    property p_pix_hold;
        ((q.rst_st == scp_pkg::SCP_RS_PIX) && !pix_rise && !commit) |=>
            (q.rst_st == scp_pkg::SCP_RS_PIX) && internal_reset;
    endproperty
    a_pix_hold: assert property (p_pix_hold)
        else $error("internal reset left without a pixel clock pulse");

endmodule

/* File: sim/scp_host.sv */
`timescale 1ns/10ps

module scp_host (
    input wire logic core_clk,
    input wire logic dev_out,
    input wire logic dev_out_oe,
    output logic sclk,
    output logic sel,
    output logic sdi
);
    int bad;

    initial begin
        sclk = 1'b0;
        sel = 1'b0;
        sdi = 1'b0;
        bad = 0;
    end

    // n rises per frame; fewer than 21 aborts by deselecting early
    task automatic xfer(input logic [2:0] cmd, input logic [7:0] a,
                        input logic [7:0] wd, input int n,
                        output logic [7:0] rd);
        logic [20:0] f;
        logic rdg;
        f = {1'b1, cmd, a, wd, 1'b0};
        rdg = (cmd == scp_pkg::CMD_READ);
        if (rdg)
            f[8:0] = 9'h000;
        rd = 8'h00;
        sel <= 1'b1;
        for (int i = 0; i < n; i++) begin
            sdi <= f[20 - i];
            repeat (5) @(negedge core_clk);
            // sampled late in the low phase: output lags the rise by ~5 cycles
            if (dev_out_oe !== (rdg && i >= 13))
                bad++;
            if (i >= 13)
                rd[20 - i] = dev_out;
            sclk <= 1'b1;
            repeat (5) @(negedge core_clk);
            sclk <= 1'b0;
        end
        repeat (5) @(negedge core_clk);
        sel <= 1'b0;
        sdi <= ~sdi;
        repeat (10) @(negedge core_clk);
        if (dev_out_oe !== 1'b0)
            bad++;
    endtask
endmodule

/* File: sim/test_serial_config_port.sv */
`timescale 1ns/10ps

module test_serial_config_port;
    logic core_clk;
    logic srst;
    logic serial_clk;
    logic serial_select;
    logic serial_in;
    logic pixel_clock;
    logic panel_power_request_in;
    logic serial_out;
    logic serial_out_oe;
    logic panel_power_on;
    logic internal_reset;
    logic [7:0] panel_control;
    logic [7:0] rd;
    int err_total;
    int compares;

    scp_port dut (
        .core_clk(core_clk),
        .srst(srst),
        .serial_clk(serial_clk),
        .serial_select(serial_select),
        .serial_in(serial_in),
        .pixel_clock(pixel_clock),
        .panel_power_request_in(panel_power_request_in),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .panel_power_on(panel_power_on),
        .internal_reset(internal_reset),
        .panel_control(panel_control)
    );

    scp_host host (
        .core_clk(core_clk),
        .dev_out(serial_out),
        .dev_out_oe(serial_out_oe),
        .sclk(serial_clk),
        .sel(serial_select),
        .sdi(serial_in)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string s);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic done_test(input string s);
        compares++;
        if (host.bad != 0) begin
            err_total++;
            $display("mismatch at %0t: output enable timing in %s", $time, s);
        end
        host.bad = 0;
        $display("test %s done", s);
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(scp_pkg::CMD_WRITE, a, d, 21, x);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                         input string s);
        host.xfer(scp_pkg::CMD_READ, a, 8'h00, 21, rd);
        check(rd, e, s);
    endtask

    // slow enough for the synchroniser to see every edge
    task automatic pix(input int n);
        repeat (n) begin
            pixel_clock <= 1'b1;
            repeat (4) @(negedge core_clk);
            pixel_clock <= 1'b0;
            repeat (4) @(negedge core_clk);
        end
    endtask

    task automatic t_reset;
        check(panel_control, scp_pkg::PANEL_CONTROL_RST, "ctl");
        check({7'h00, internal_reset}, 8'h01, "irst");
        check({7'h00, serial_out_oe}, 8'h00, "oe");
        pix(10);
        check({7'h00, internal_reset}, 8'h01, "pix early");
        wr(8'h00, 8'h11);
        pix(9);
        check({7'h00, internal_reset}, 8'h01, "pix 9");
        pix(1);
        repeat (6) @(negedge core_clk);
        check({7'h00, internal_reset}, 8'h00, "pix 10");
        done_test("reset");
    endtask

    task automatic t_rw;
        logic [7:0] al [6];
        al = '{8'h00, 8'h01, 8'h3F, 8'h40, 8'h9C, 8'hFF};
        foreach (al[i]) wr(al[i], al[i] ^ 8'hC5);
        foreach (al[i]) rdchk(al[i], al[i] ^ 8'hC5, "rw");
        done_test("rw");
    endtask

    task automatic t_lock;
        panel_power_request_in <= 1'b1;
        repeat (8) @(negedge core_clk);
        check({7'h00, panel_power_on}, 8'h00, "pwr idle");
        wr(8'h02, 8'h40);
        check(panel_control, 8'h40, "run");
        check({7'h00, panel_power_on}, 8'h01, "pwr on");
        panel_power_request_in <= 1'b0;
        repeat (8) @(negedge core_clk);
        check({7'h00, panel_power_on}, 8'h00, "pwr req");
        wr(8'h01, 8'h77);
        wr(8'h40, 8'h77);
        wr(8'h03, 8'h2A);
        rdchk(8'h01, 8'hC4, "lock reg");
        rdchk(8'h40, scp_pkg::LOCKED_READ_VALUE, "lock pat");
        rdchk(8'h03, 8'h2A, "aux");
        wr(8'h02, 8'h00);
        rdchk(8'h40, 8'h85, "pat kept");
        done_test("lock");
    endtask

    task automatic t_cmd;
        for (int c = 2; c < 8; c++) begin
            host.xfer(3'(c), 8'h01, 8'hFF, 21, rd);
        end
        host.xfer(scp_pkg::CMD_READ, 8'h01, 8'h00, 16, rd);
        rdchk(8'h01, 8'hC4, "bad cmd");
        done_test("cmd");
    endtask

    task automatic t_soft;
        wr(8'h02, 8'h03);
        wr(8'h03, 8'h81);
        check(panel_control, 8'h00, "soft ctl");
        check({7'h00, internal_reset}, 8'h01, "soft irst");
        rdchk(8'h03, 8'h01, "soft aux");
        pix(10);
        repeat (6) @(negedge core_clk);
        check({7'h00, internal_reset}, 8'h00, "soft end");
        done_test("soft");
    endtask

    initial begin
        #200000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        err_total = 0;
        compares = 0;
        srst = 1'b1;
        pixel_clock = 1'b0;
        panel_power_request_in = 1'b0;
        repeat (12) @(negedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_rw();
        t_lock();
        t_cmd();
        t_soft();
        complete_run();
    end
endmodule
